// ==== hdl/atatf_pkg.sv ====
// Constants and field layout of the task-file address and status register bank
// Behaviour
// - Offset 3 holds the start sector, or block address bits 7..0.
// - Offset 4 holds cylinder low byte, or block address bits 15..8.
// - Offset 5 holds cylinder high byte, or block address bits 23..16.
// - Unit/head register bits 7 and 5 always read one.
// - Unit/head bit 6 picks cylinder/head/sector (0) or block (1) addressing.
// - Block address is built from sector, cylinder low/high and head nibble.
// - Cylinder/head/sector mode takes unit/head bits 3..0 as head number.
// - Unit/head bit 4 picks unit 0 or 1; own unit from configuration.
// - Reading primary status at offset 7 clears the pending interrupt.
// - Reading shadow status at offset E returns status, keeps interrupt pending.
// - While busy the host may not use registers; other bits invalid.
// - Ready bit is zero from power-up until the card accepts commands.
// - Bit 5 shows a write fault, bit 4 shows the card is ready.
// - Bit 3 set while data must move; cleared by the next command.
// - Bit 2 shows a corrected error; bit 1 always reads zero.
// - Bit 0 shows previous command failed; failing sector kept in address registers.
// - Host control register at offset E is writable even while busy.
// - Control bit 2 holds the card in soft reset, clears status, loads diagnostics.
// - Control bit 1 masks the interrupt, drives configuration bit, resets to zero.
// - Readback bit 6 reads zero while a write runs, else one.
// - Readback bits 5..2 are inverted unit/head bits 3..0.
// - Readback bits 1 and 0 read zero when unit 1 or 0 is active and selected.
package atatf_pkg;
    localparam logic [3:0] OFF_SECTOR = 4'h3;
    localparam logic [3:0] OFF_CYL_LOW = 4'h4;
    localparam logic [3:0] OFF_CYL_HIGH = 4'h5;
    localparam logic [3:0] OFF_UNIT_HEAD = 4'h6;
    localparam logic [3:0] OFF_STATUS = 4'h7;
    localparam logic [3:0] OFF_SHADOW = 4'he;
    localparam logic [3:0] OFF_CONTROL = 4'he;
    localparam logic [3:0] OFF_READBACK = 4'hf;
    localparam int UH_LBA = 6;
    localparam int UH_UNIT = 4;
    localparam logic [7:0] UH_FORCED = 8'ha0;
    localparam int CTRL_SRST = 2;
    localparam int CTRL_MASK = 1;
    localparam logic [7:0] CTRL_KEEP = 8'h06;
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_WFAULT = 5;
    localparam int ST_SEEK = 4;
    localparam int ST_XFER_REQ = 3;
    localparam int ST_CORRECTED = 2;
    localparam int ST_INDEX = 1;
    localparam int ST_ERR = 0;
    localparam int RB_WRITE = 6;
    localparam logic [7:0] RST_SECTOR = 8'h01;
    localparam logic [7:0] RST_CYL = 8'h00;
    localparam logic [7:0] RST_UNIT_HEAD = 8'ha0;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    localparam int RESET_SYNC_STAGES = 2;
endpackage

// ==== hdl/atatf_wr_if.sv ====
// Host write strobe carrier between the bank's own modules
`timescale 1ns/1ns
interface atatf_wr_if;
    logic [3:0] addr;
    logic [7:0] data;
    logic wr;
    logic busy;
    modport master (output addr, output data, output wr, output busy);
    modport slave (input addr, input data, input wr, input busy);
endinterface

// ==== hdl/atatf_addr.sv ====
// Start address registers: sector, cylinder low/high and unit/head
`timescale 1ns/1ns
module atatf_addr
    import atatf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    atatf_wr_if.slave bus,
    input wire logic fail_load,
    input wire logic [27:0] fail_addr,
    output logic [7:0] sector_q,
    output logic [7:0] cyl_low_q,
    output logic [7:0] cyl_high_q,
    output logic [7:0] unit_head_q
);
    logic host_wr;

    // Host writes refused while the card owns the task file
    assign host_wr = bus.wr && !bus.busy;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sector_q <= RST_SECTOR;
            cyl_low_q <= RST_CYL;
            cyl_high_q <= RST_CYL;
            unit_head_q <= RST_UNIT_HEAD;
        end else if (fail_load) begin
            // First failing sector reported by the core
            sector_q <= fail_addr[7:0];
            cyl_low_q <= fail_addr[15:8];
            cyl_high_q <= fail_addr[23:16];
            unit_head_q <= {unit_head_q[7:4], fail_addr[27:24]} | UH_FORCED;
        end else if (host_wr) begin
            if (bus.addr == OFF_SECTOR) sector_q <= bus.data;
            if (bus.addr == OFF_CYL_LOW) cyl_low_q <= bus.data;
            if (bus.addr == OFF_CYL_HIGH) cyl_high_q <= bus.data;
            if (bus.addr == OFF_UNIT_HEAD) unit_head_q <= bus.data | UH_FORCED;
        end
    end
endmodule

// ==== hdl/atatf_ctrl.sv ====
// Write-only host control register: soft reset and interrupt mask
`timescale 1ns/1ns
module atatf_ctrl
    import atatf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    atatf_wr_if.slave bus,
    output logic soft_reset_bit,
    output logic irq_mask
);
    logic [7:0] control_q;

    // Busy is deliberately not consulted here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_q <= RST_CONTROL;
        end else if (bus.wr && bus.addr == OFF_CONTROL) begin
            control_q <= bus.data & CTRL_KEEP;
        end
    end

    assign soft_reset_bit = control_q[CTRL_SRST];
    assign irq_mask = control_q[CTRL_MASK];
endmodule

// ==== hdl/atatf_top.sv ====
// Task-file address, status, control and readback register bank
`timescale 1ns/1ns
module atatf_top
    import atatf_pkg::*;
#(
    parameter int ADDR_W = 4
)
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    input wire logic core_busy,
    input wire logic core_ready,
    input wire logic core_write_fault,
    input wire logic core_xfer_req_set,
    input wire logic core_xfer_req_clear,
    input wire logic core_corrected,
    input wire logic core_cmd_error,
    input wire logic command_start,
    input wire logic core_irq_event,
    input wire logic write_in_progress,
    input wire logic unit_number,
    input wire logic fail_load,
    input wire logic [27:0] fail_addr,
    output logic card_interrupt_request_q,
    output logic soft_reset_q,
    output logic int_disable_q,
    output logic diag_load_q,
    output logic lba_mode_q,
    output logic [27:0] lba_addr_q,
    output logic [15:0] cylinder_q,
    output logic [3:0] head_q,
    output logic [7:0] start_sector_q,
    output logic unit_select_q,
    output logic unit_match_q
);
    import atatf_pkg::*;

    // Offset decode below is fixed at four bits
    if (ADDR_W != 4) begin : g_addr_w_check
        $error("atatf_top serves a four-bit offset only");
    end

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [7:0] pack_status(
        input logic busy,
        input logic rdy,
        input logic wf,
        input logic xreq,
        input logic fixed,
        input logic err
    );
        logic [7:0] s;
        s = 8'h00;
        s[ST_BUSY] = busy;
        s[ST_READY] = rdy;
        s[ST_WFAULT] = wf;
        s[ST_SEEK] = rdy;
        s[ST_XFER_REQ] = xreq;
        s[ST_CORRECTED] = fixed;
        s[ST_INDEX] = 1'b0;
        s[ST_ERR] = err;
        pack_status = s;
    endfunction

    // Reset release synchroniser
    logic [RESET_SYNC_STAGES-1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_q <= '0;
        end else begin
            rst_sync_q <= {rst_sync_q[RESET_SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[RESET_SYNC_STAGES-1];

    // Internal write carrier
    atatf_wr_if wr_bus ();

    assign wr_bus.addr = reg_addr;
    assign wr_bus.data = reg_wdata;
    assign wr_bus.wr = reg_wr;
    assign wr_bus.busy = core_busy;

    logic [7:0] sector_r;
    logic [7:0] cyl_low_r;
    logic [7:0] cyl_high_r;
    logic [7:0] unit_head_r;
    logic srst;
    logic mask;

    atatf_addr u_addr (
        .clk(core_clk),
        .rst_n(rst_n),
        .bus(wr_bus),
        .fail_load(fail_load),
        .fail_addr(fail_addr),
        .sector_q(sector_r),
        .cyl_low_q(cyl_low_r),
        .cyl_high_q(cyl_high_r),
        .unit_head_q(unit_head_r)
    );

    atatf_ctrl u_ctrl (
        .clk(core_clk),
        .rst_n(rst_n),
        .bus(wr_bus),
        .soft_reset_bit(srst),
        .irq_mask(mask)
    );

    // Status flags
    logic ready_q;
    logic xfer_req_q;
    logic corrected_q;
    logic err_q;
    logic wfault_q;
    logic irq_pend_q;
    logic srst_q;
    logic [7:0] status_byte;
    logic status_rd;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= core_ready && !srst;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wfault_q <= 1'b0;
        end else begin
            wfault_q <= core_write_fault && !srst;
        end
    end

    // Sticky flags: the setting event wins over a same-cycle command start or clear input; soft reset wins over the setting event
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_req_q <= 1'b0;
        end else if (srst) begin
            xfer_req_q <= 1'b0;
        end else if (core_xfer_req_set) begin
            xfer_req_q <= 1'b1;
        end else if (command_start || core_xfer_req_clear) begin
            xfer_req_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            corrected_q <= 1'b0;
        end else if (srst) begin
            corrected_q <= 1'b0;
        end else if (core_corrected) begin
            corrected_q <= 1'b1;
        end else if (command_start) begin
            corrected_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else if (srst) begin
            err_q <= 1'b0;
        end else if (core_cmd_error) begin
            err_q <= 1'b1;
        end else if (command_start) begin
            err_q <= 1'b0;
        end
    end

    assign status_byte = srst ? 8'h00 :
        pack_status(core_busy, ready_q, wfault_q, xfer_req_q, corrected_q, err_q);
    assign status_rd = reg_rd && hit(reg_addr, OFF_STATUS);

    // Pending interrupt; the primary status read or soft reset clears it, the shadow read does not
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pend_q <= 1'b0;
        end else if (srst) begin
            irq_pend_q <= 1'b0;
        end else if (core_irq_event) begin
            irq_pend_q <= 1'b1;
        end else if (status_rd) begin
            irq_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            card_interrupt_request_q <= 1'b0;
            int_disable_q <= 1'b0;
        end else begin
            card_interrupt_request_q <= irq_pend_q && !mask;
            int_disable_q <= mask;
        end
    end

    // Soft reset output and diagnostic load on entry
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            srst_q <= 1'b0;
            soft_reset_q <= 1'b0;
            diag_load_q <= 1'b0;
        end else begin
            srst_q <= srst;
            soft_reset_q <= srst;
            diag_load_q <= srst && !srst_q;
        end
    end

    // Address decode toward the core
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lba_mode_q <= 1'b0;
            lba_addr_q <= '0;
            cylinder_q <= '0;
            head_q <= '0;
            start_sector_q <= RST_SECTOR;
            unit_select_q <= 1'b0;
            unit_match_q <= 1'b0;
        end else begin
            lba_mode_q <= unit_head_r[UH_LBA];
            lba_addr_q <= {unit_head_r[3:0], cyl_high_r, cyl_low_r, sector_r};
            cylinder_q <= {cyl_high_r, cyl_low_r};
            head_q <= unit_head_r[3:0];
            start_sector_q <= sector_r;
            unit_select_q <= unit_head_r[UH_UNIT];
            unit_match_q <= unit_head_r[UH_UNIT] == unit_number;
        end
    end

    // Readback byte at offset F
    logic [7:0] readback_byte;
    logic selected;

    assign selected = core_ready && (unit_head_r[UH_UNIT] == unit_number);

    always_comb begin
        readback_byte = 8'h00;
        readback_byte[RB_WRITE] = !write_in_progress;
        readback_byte[5:2] = ~unit_head_r[3:0];
        readback_byte[1] = !(selected && unit_number);
        readback_byte[0] = !(selected && !unit_number);
    end

    // Read data mux; offsets owned elsewhere read as zero
    logic [7:0] rd_mux;

    always_comb begin
        unique case (reg_addr)
            OFF_SECTOR: rd_mux = sector_r;
            OFF_CYL_LOW: rd_mux = cyl_low_r;
            OFF_CYL_HIGH: rd_mux = cyl_high_r;
            OFF_UNIT_HEAD: rd_mux = unit_head_r;
            OFF_STATUS: rd_mux = status_byte;
            OFF_SHADOW: rd_mux = status_byte;
            OFF_READBACK: rd_mux = readback_byte;
            default: rd_mux = RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= RD_UNMAPPED;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_mux;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_head_forced_ones: assert property (
        reg_rd && hit(reg_addr, OFF_UNIT_HEAD) |=> reg_rdata_q[7] && reg_rdata_q[5])
        else $error("unit/head bits 7 and 5 not read as one");

    a_status_read_clears: assert property (
        status_rd && !core_irq_event && !srst |=> !irq_pend_q ##1 !card_interrupt_request_q)
        else $error("primary status read left interrupt pending");

    a_shadow_keeps_irq: assert property (
        reg_rd && hit(reg_addr, OFF_SHADOW) && irq_pend_q && !srst |=> irq_pend_q)
        else $error("shadow status read cleared interrupt");

    a_busy_write_refused: assert property (
        reg_wr && core_busy && !fail_load && hit(reg_addr, OFF_SECTOR)
        |=> $stable(sector_r))
        else $error("address register written while busy");

    a_ready_follows_core: assert property (
        !core_ready |=> !ready_q)
        else $error("ready shown while core not ready");

    a_xfer_req_cleared: assert property (
        command_start && !core_xfer_req_set |=> !xfer_req_q)
        else $error("transfer request not cleared by next command");

    a_err_set_wins: assert property (
        core_cmd_error && command_start && !srst |=> err_q)
        else $error("error event lost against command clear");

    a_status_bit1_zero: assert property (
        reg_rd && (hit(reg_addr, OFF_STATUS) || hit(reg_addr, OFF_SHADOW))
        |=> !reg_rdata_q[ST_INDEX])
        else $error("status bit 1 not zero");

    a_ctrl_write_busy: assert property (
        reg_wr && core_busy && hit(reg_addr, OFF_CONTROL)
        |=> srst == $past(reg_wdata[CTRL_SRST]) && mask == $past(reg_wdata[CTRL_MASK]))
        else $error("control write not taken while busy");

    a_srst_diag_pulse: assert property (
        $rose(srst) |=> diag_load_q && soft_reset_q ##1 !diag_load_q)
        else $error("soft reset entry did not pulse diagnostic load");

    a_mask_gates_irq: assert property (
        mask |=> !card_interrupt_request_q)
        else $error("interrupt raised while masked");

    a_lba_build: assert property (
        1'b1 |=> lba_addr_q == {$past(unit_head_r[3:0]), $past(cyl_high_r),
            $past(cyl_low_r), $past(sector_r)})
        else $error("block address built wrongly");

    a_readback_head: assert property (
        reg_rd && hit(reg_addr, OFF_READBACK)
        |=> reg_rdata_q[5:2] == ~$past(unit_head_r[3:0])
            && reg_rdata_q[RB_WRITE] == !$past(write_in_progress))
        else $error("readback head or write bit wrong");
endmodule

// ==== verif/atatf_host_model.sv ====
// Host controller model issuing byte register cycles to the bank
`timescale 1ns/1ns
module atatf_host_model (
    input wire logic core_clk,
    output logic [3:0] reg_addr,
    output logic reg_rd,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_q,
    input wire logic core_busy
);
    initial begin
        reg_addr = 4'h0;
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end

    // Polite host skips writes to offsets 3..7 while busy unless told to insist
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit insist);
        if (core_busy === 1'b1 && a >= 4'h3 && a <= 4'h7 && !insist) begin
            return;
        end
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata_q;
    endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the task-file address and status bank
`timescale 1ns/1ns
module testbench;
    import atatf_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic core_busy = 1'b0;
    logic core_ready = 1'b0;
    logic core_write_fault = 1'b0;
    logic write_in_progress = 1'b0;
    logic unit_number = 1'b0;
    logic [27:0] fail_addr = 28'h0000000;
    logic [6:0] pls = 7'h00;
    logic [3:0] reg_addr;
    logic reg_rd;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata_q;
    logic card_interrupt_request_q;
    logic soft_reset_q;
    logic int_disable_q;
    logic diag_load_q;
    logic lba_mode_q;
    logic [27:0] lba_addr_q;
    logic [15:0] cylinder_q;
    logic [3:0] head_q;
    logic [7:0] start_sector_q;
    logic unit_select_q;
    logic unit_match_q;
    logic [31:0] rnd = 32'h000177f1;
    int n_fail = 0;
    int check_count = 0;
    int diag_n = 0;
    logic [7:0] v;
    logic [7:0] s;
    logic [7:0] cl;
    logic [7:0] ch;
    logic [7:0] uh;

    always #25 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (diag_load_q === 1'b1) begin
            diag_n++;
        end
    end

    atatf_host_model host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .core_busy(core_busy));

    atatf_top #(.ADDR_W(4)) uut (.core_clk(core_clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .core_busy(core_busy), .core_ready(core_ready),
        .core_write_fault(core_write_fault), .core_xfer_req_set(pls[0]),
        .core_xfer_req_clear(pls[1]), .core_corrected(pls[2]), .core_cmd_error(pls[3]),
        .command_start(pls[4]), .core_irq_event(pls[5]),
        .write_in_progress(write_in_progress), .unit_number(unit_number),
        .fail_load(pls[6]), .fail_addr(fail_addr),
        .card_interrupt_request_q(card_interrupt_request_q), .soft_reset_q(soft_reset_q),
        .int_disable_q(int_disable_q), .diag_load_q(diag_load_q), .lba_mode_q(lba_mode_q),
        .lba_addr_q(lba_addr_q), .cylinder_q(cylinder_q), .head_q(head_q),
        .start_sector_q(start_sector_q), .unit_select_q(unit_select_q),
        .unit_match_q(unit_match_q));

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [7:0] st_exp(input logic b, input logic r, input logic wf,
        input logic xr, input logic cor, input logic err);
        return {b, r, wf, r, xr, cor, 1'b0, err};
    endfunction

    function automatic logic [7:0] rb_exp(input logic wip, input logic [7:0] h,
        input logic rdy, input logic un);
        logic sel;
        sel = rdy && (h[4] == un);
        return {1'b0, ~wip, ~h[3:0], !(sel && un), !(sel && !un)};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Core event pulses last exactly one cycle, then settle
    task automatic pulse(input logic [6:0] m);
        @(posedge core_clk);
        pls <= m;
        @(posedge core_clk);
        pls <= 7'h00;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #250000;
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        host.rd(OFF_SECTOR, v);
        check(v, RST_SECTOR);
        host.rd(OFF_UNIT_HEAD, v);
        check(v, RST_UNIT_HEAD);
        host.rd(OFF_STATUS, v);
        check(v, 8'h00);
        host.rd(4'h9, v);
        check(v, RD_UNMAPPED);
        $display("test reset done");

        for (int i = 0; i < 10; i++) begin
            rnd = lfsr_next(rnd);
            s = rnd[7:0];
            cl = rnd[15:8];
            ch = rnd[23:16];
            uh = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[31:24];
            @(posedge core_clk);
            write_in_progress <= rnd[3];
            core_ready <= rnd[9];
            unit_number <= rnd[17];
            host.wr(OFF_SECTOR, s, 1'b0);
            host.wr(OFF_CYL_LOW, cl, 1'b0);
            host.wr(OFF_CYL_HIGH, ch, 1'b0);
            host.wr(OFF_UNIT_HEAD, uh, 1'b0);
            host.rd(OFF_SECTOR, v);
            check(v, s);
            host.rd(OFF_CYL_LOW, v);
            check(v, cl);
            host.rd(OFF_CYL_HIGH, v);
            check(v, ch);
            host.rd(OFF_UNIT_HEAD, v);
            check(v, uh | 8'ha0);
            check(lba_mode_q, uh[6]);
            check(lba_addr_q, {uh[3:0], ch, cl, s});
            check(head_q, uh[3:0]);
            check(cylinder_q, {ch, cl});
            check(start_sector_q, s);
            check(unit_select_q, uh[4]);
            check(unit_match_q, uh[4] == rnd[17]);
            host.rd(OFF_READBACK, v);
            check(v, rb_exp(rnd[3], uh, rnd[9], rnd[17]));
        end
        $display("test address done");

        @(posedge core_clk);
        core_busy <= 1'b1;
        core_ready <= 1'b1;
        write_in_progress <= 1'b0;
        host.wr(OFF_SECTOR, ~s, 1'b1);
        host.wr(OFF_CONTROL, 8'h02, 1'b0);
        host.rd(OFF_SECTOR, v);
        check(v, s);
        check(int_disable_q, 1'b1);
        host.rd(OFF_SHADOW, v);
        check(v[7], 1'b1);
        @(posedge core_clk);
        core_busy <= 1'b0;
        host.wr(OFF_CONTROL, 8'h00, 1'b0);
        @(posedge core_clk);
        #1;
        check(int_disable_q, 1'b0);
        $display("test busy done");

        @(posedge core_clk);
        core_write_fault <= 1'b1;
        pulse(7'h0d);
        host.rd(OFF_STATUS, v);
        check(v, st_exp(0, 1, 1, 1, 1, 1));
        pulse(7'h02);
        host.rd(OFF_SHADOW, v);
        check(v, st_exp(0, 1, 1, 0, 1, 1));
        pulse(7'h11);
        pulse(7'h10);
        host.rd(OFF_STATUS, v);
        check(v, st_exp(0, 1, 1, 0, 0, 0));
        // Error event and next command in one cycle: the error wins
        pulse(7'h18);
        host.rd(OFF_STATUS, v);
        check(v, st_exp(0, 1, 1, 0, 0, 1));
        rnd = lfsr_next(rnd);
        fail_addr <= rnd[27:0];
        pulse(7'h40);
        check(lba_addr_q, rnd[27:0]);
        host.rd(OFF_SECTOR, v);
        check(v, rnd[7:0]);
        $display("test status done");

        pulse(7'h20);
        check(card_interrupt_request_q, 1'b1);
        host.wr(OFF_CONTROL, 8'h02, 1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        check(card_interrupt_request_q, 1'b0);
        host.wr(OFF_CONTROL, 8'h00, 1'b0);
        repeat (2) @(posedge core_clk);
        #1;
        check(card_interrupt_request_q, 1'b1);
        host.rd(OFF_SHADOW, v);
        repeat (2) @(posedge core_clk);
        #1;
        check(card_interrupt_request_q, 1'b1);
        host.rd(OFF_STATUS, v);
        repeat (2) @(posedge core_clk);
        #1;
        check(card_interrupt_request_q, 1'b0);
        $display("test interrupt done");

        pulse(7'h01);
        diag_n = 0;
        host.wr(OFF_CONTROL, 8'h04, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        check(soft_reset_q, 1'b1);
        check(diag_n, 1);
        host.rd(OFF_STATUS, v);
        check(v, 8'h00);
        host.wr(OFF_CONTROL, 8'h00, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        check(soft_reset_q, 1'b0);
        host.rd(OFF_STATUS, v);
        check(v, st_exp(0, 1, 1, 0, 0, 0));
        $display("test soft reset done");
        give_verdict();
    end
endmodule
